// ### src/dmma_core.sv
`timescale 1ns/100ps
// Behaviour
// RULE_01 - one overflow flag per accumulator at bits 16 and 18, 32-bit range
// RULE_02 - overflow flag reads 1 after overflow or underflow, else 0
// RULE_03 - sticky flags set with overflow flags, kept through clean ops
// RULE_04 - extraction saturation sets bit 24 and sticky bit 25
// RULE_05 - direct multiply to register updates only extraction flags
// RULE_06 - accumulate without extraction updates only accumulator flags
// RULE_07 - accumulate with extraction updates both flag groups
// RULE_08 - low half uses accumulator zero, high half accumulator one
// RULE_09 - no format option means signed fraction operands
// RULE_10 - signed int, unsigned fraction, unsigned int: no shift correction
// RULE_11 - truncating options drop low 16 bits to half register
// RULE_12 - scaled signed int full target doubles then saturates 32 bits
// RULE_13 - scaled signed int half target doubles, saturates 16 bits
// RULE_14 - integer high half: round, saturate 32, write bits 31 to 16
// RULE_15 - legacy option: signed fraction, 32-bit accumulator, product shift
// RULE_16 - legacy option only: most negative squared gives largest positive
// RULE_17 - mixed format only on unit one: signed by unsigned, no shift
// RULE_18 - mixed format alone or with one other format option
// RULE_19 - operands picked from either half of each input word
// RULE_20 - both input words may hold the same register value
// RULE_21 - product enters 40-bit adder: add, subtract or pass through
// RULE_22 - 40-bit accumulators, word and extension separately addressable
// RULE_23 - signed fraction products shifted left one place
// RULE_24 - loaded 32-bit result sign-extended into extension bits
// RULE_25 - high half rounding adds 0x8000 before 32-bit saturation
// RULE_26 - sticky flags cleared only by explicit flag register write
module dmma_core #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // ----------------------------------------------------------------
    // arithmetic helpers
    // ----------------------------------------------------------------
    function automatic logic [39:0] mulProd(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic        sa,
        input logic        sb,
        input logic        shl,
        input logic        legacy
    );
        logic signed [16:0] ea;
        logic signed [16:0] eb;
        logic signed [33:0] pr;
        logic [39:0]        r;
        ea = {sa & a[15], a};
        eb = {sb & b[15], b};
        pr = ea * eb;
        r  = {{6{pr[33]}}, pr};
        if (shl) begin
            r = {r[38:0], 1'b0}; // RULE_23
        end
        if (legacy && a == dmma_pkg::MOST_NEG16
                && b == dmma_pkg::MOST_NEG16) begin
            r = dmma_pkg::LEGACY_SQR; // RULE_16
        end
        return r;
    endfunction

    // returns {overflow, value}
    function automatic logic [32:0] sat32(
        input logic [39:0] v,
        input logic        uns
    );
        logic [32:0] r;
        r = {1'b0, v[31:0]};
        if (uns) begin
            if (v[39]) begin
                r = {1'b1, 32'h0000_0000};
            end else if (v[39:32] != 8'h00) begin
                r = {1'b1, 32'hFFFF_FFFF};
            end
        end else if (v[39:31] != {9{v[39]}}) begin
            r = {1'b1, v[39] ? dmma_pkg::SMIN32 : dmma_pkg::SMAX32};
        end
        return r;
    endfunction

    function automatic logic [16:0] sat16(
        input logic [39:0] v,
        input logic        uns
    );
        logic [16:0] r;
        r = {1'b0, v[15:0]};
        if (uns) begin
            if (v[39]) begin
                r = {1'b1, 16'h0000};
            end else if (v[39:16] != 24'h00_0000) begin
                r = {1'b1, 16'hFFFF};
            end
        end else if (v[39:15] != {25{v[39]}}) begin
            r = {1'b1, v[39] ? dmma_pkg::SMIN16 : dmma_pkg::SMAX16};
        end
        return r;
    endfunction

    // extraction to a full or half register; half data in low 16 bits
    function automatic logic [32:0] extract(
        input logic [39:0]         v,
        input dmma_pkg::dmma_fmt_e fmt,
        input logic                full,
        input logic                uns
    );
        logic [32:0] w;
        logic [16:0] h;
        logic [39:0] dbl;
        w   = '0;
        h   = '0;
        dbl = {v[38:0], 1'b0};
        case (fmt)
            dmma_pkg::FMT_SINT_X2: begin
                w = sat32(dbl, 1'b0); // RULE_12
                h = sat16(dbl, 1'b0); // RULE_13
            end
            dmma_pkg::FMT_SINT, dmma_pkg::FMT_UINT: begin
                w = sat32(v, uns);
                h = sat16(v, uns);
            end
            dmma_pkg::FMT_TRUNC, dmma_pkg::FMT_UFRAC_TRUNC: begin
                w = sat32(v, uns);
                h = {w[32], w[31:16]}; // RULE_11
            end
            default: begin
                w = sat32(v, uns);
                w = sat32(v + dmma_pkg::RND_HALF, uns); // RULE_25
                h = {w[32], w[31:16]}; // RULE_14
                w = sat32(v, uns);
            end
        endcase
        return full ? w : {h[16], 16'h0000, h[15:0]};
    endfunction

    function automatic logic [31:0] readMux(
        input dmma_pkg::dmma_state_s s,
        input logic [ADDR_W-1:0]     a
    );
        logic [31:0] d;
        d = '0;
        case (a)
            dmma_pkg::OFS_OPND_A:   d = s.opndA;
            dmma_pkg::OFS_OPND_B:   d = s.opndB;
            dmma_pkg::OFS_CMD:      d = s.cmd;
            dmma_pkg::OFS_FLAGS: begin
                d[dmma_pkg::FLG_ACC0_OVF]  = s.accOvf[0];
                d[dmma_pkg::FLG_ACC0_STKY] = s.accOvfSticky[0];
                d[dmma_pkg::FLG_ACC1_OVF]  = s.accOvf[1];
                d[dmma_pkg::FLG_ACC1_STKY] = s.accOvfSticky[1];
                d[dmma_pkg::FLG_EXT_SAT]   = s.extSat;
                d[dmma_pkg::FLG_EXT_STKY]  = s.extSatSticky;
            end
            dmma_pkg::OFS_RES_ZERO: d = s.res[0];
            dmma_pkg::OFS_RES_ONE:  d = s.res[1];
            dmma_pkg::OFS_RES_HALF: d = s.resHalf;
            dmma_pkg::OFS_ACC0_W:   d = s.acc[0][31:0];
            dmma_pkg::OFS_ACC0_X:   d = {24'h00_0000, s.acc[0][39:32]};
            dmma_pkg::OFS_ACC1_W:   d = s.acc[1][31:0];
            dmma_pkg::OFS_ACC1_X:   d = {24'h00_0000, s.acc[1][39:32]};
            default:                d = '0;
        endcase
        return d;
    endfunction

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return a == dmma_pkg::OFS_OPND_A   || a == dmma_pkg::OFS_OPND_B ||
               a == dmma_pkg::OFS_CMD      || a == dmma_pkg::OFS_FLAGS ||
               a == dmma_pkg::OFS_RES_ZERO || a == dmma_pkg::OFS_RES_ONE ||
               a == dmma_pkg::OFS_RES_HALF || a == dmma_pkg::OFS_ACC0_W ||
               a == dmma_pkg::OFS_ACC0_X   || a == dmma_pkg::OFS_ACC1_W ||
               a == dmma_pkg::OFS_ACC1_X;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dmma_pkg::dmma_state_s r_q;
    dmma_pkg::dmma_state_s r_d;
    logic                  wrEn;

    // stall one extra cycle after an operation so read data is settled
    assign pready  = psel & penable & ~r_q.pend & ~r_q.done;
    assign pslverr = pready & ~isMapped(paddr);
    assign wrEn    = pready & pwrite & isMapped(paddr);
    assign prdata  = r_q.rdData;

    always_comb begin
        dmma_pkg::dmma_fmt_e   fmt;
        dmma_pkg::dmma_accop_e op;
        logic [7:0]            c;
        logic [15:0]           a;
        logic [15:0]           b;
        logic                  sa;
        logic                  sb;
        logic                  shl;
        logic                  uns;
        logic                  mix;
        logic                  legacy;
        logic                  doExt;
        logic                  extAny;
        logic                  extOvf;
        logic [39:0]           p;
        logic [39:0]           nv;
        logic [32:0]           sw;
        logic [39:0]           v;
        logic [32:0]           ex;
        r_d    = r_q;
        fmt    = dmma_pkg::FMT_DEF;
        op     = dmma_pkg::ACC_NONE;
        c      = '0;
        a      = '0;
        b      = '0;
        sa     = 1'b1;
        sb     = 1'b1;
        shl    = 1'b1;
        uns    = 1'b0;
        mix    = 1'b0;
        legacy = 1'b0;
        doExt  = 1'b0;
        extAny = 1'b0;
        extOvf = 1'b0;
        p      = '0;
        nv     = '0;
        sw     = '0;
        v      = '0;
        ex     = '0;

        r_d.done   = r_q.pend;
        r_d.pend   = 1'b0;
        r_d.rdData = readMux(r_q, paddr);

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wrEn) begin
            case (paddr)
                dmma_pkg::OFS_OPND_A: r_d.opndA = pwdata;
                dmma_pkg::OFS_OPND_B: r_d.opndB = pwdata;
                dmma_pkg::OFS_CMD: begin
                    r_d.cmd  = pwdata;
                    r_d.pend = 1'b1;
                end
                dmma_pkg::OFS_FLAGS: begin
                    r_d.accOvf[0]       = pwdata[dmma_pkg::FLG_ACC0_OVF];
                    r_d.accOvf[1]       = pwdata[dmma_pkg::FLG_ACC1_OVF];
                    r_d.extSat          = pwdata[dmma_pkg::FLG_EXT_SAT];
                    // only path that can clear the sticky bits
                    r_d.accOvfSticky[0] = pwdata[dmma_pkg::FLG_ACC0_STKY]; // RULE_26
                    r_d.accOvfSticky[1] = pwdata[dmma_pkg::FLG_ACC1_STKY]; // RULE_26
                    r_d.extSatSticky    = pwdata[dmma_pkg::FLG_EXT_STKY]; // RULE_26
                end
                dmma_pkg::OFS_ACC0_W: r_d.acc[0][31:0]  = pwdata; // RULE_22
                dmma_pkg::OFS_ACC0_X: r_d.acc[0][39:32] = pwdata[7:0]; // RULE_22
                dmma_pkg::OFS_ACC1_W: r_d.acc[1][31:0]  = pwdata; // RULE_22
                dmma_pkg::OFS_ACC1_X: r_d.acc[1][39:32] = pwdata[7:0]; // RULE_22
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // operation, one cycle after the command write
        // ------------------------------------------------------------
        if (r_q.pend) begin
            fmt = dmma_pkg::dmma_fmt_e'(r_q.cmd[dmma_pkg::CMD_FMT_LO +: 4]);
            // mixed bit is separate, so at most one other option rides along
            mix = r_q.cmd[dmma_pkg::CMD_MIX]; // RULE_18
            legacy = (fmt == dmma_pkg::FMT_LEGACY);
            for (int u = 0; u < 2; u++) begin
                c  = r_q.cmd[dmma_pkg::CMD_UNIT_W*u +: dmma_pkg::CMD_UNIT_W];
                op = dmma_pkg::dmma_accop_e'(c[dmma_pkg::CMD_OP_LO +: 2]);
                // same register may feed both words; halves chosen freely
                a  = c[dmma_pkg::CMD_SEL_A] ? r_q.opndA[31:16]
                                            : r_q.opndA[15:0]; // RULE_19 RULE_20
                b  = c[dmma_pkg::CMD_SEL_B] ? r_q.opndB[31:16]
                                            : r_q.opndB[15:0]; // RULE_19 RULE_20
                case (fmt)
                    dmma_pkg::FMT_SINT, dmma_pkg::FMT_SINT_X2,
                    dmma_pkg::FMT_INT_HIGH: begin
                        sa  = 1'b1;
                        sb  = 1'b1;
                        shl = 1'b0; // RULE_10
                        uns = 1'b0;
                    end
                    dmma_pkg::FMT_UFRAC, dmma_pkg::FMT_UFRAC_TRUNC,
                    dmma_pkg::FMT_UINT: begin
                        sa  = 1'b0;
                        sb  = 1'b0;
                        shl = 1'b0; // RULE_10
                        uns = 1'b1;
                    end
                    default: begin
                        sa  = 1'b1; // RULE_09 RULE_15
                        sb  = 1'b1;
                        shl = 1'b1;
                        uns = 1'b0;
                    end
                endcase
                // unit zero ignores the mixed bit and keeps its format
                if (mix && u == 1) begin
                    sa  = 1'b1; // RULE_17
                    sb  = 1'b0;
                    shl = 1'b0;
                    uns = 1'b0;
                end
                p = mulProd(a, b, sa, sb, shl, legacy);

                case (op)
                    dmma_pkg::ACC_ADD: nv = r_q.acc[u] + p; // RULE_21
                    dmma_pkg::ACC_SUB: nv = r_q.acc[u] - p; // RULE_21
                    default:           nv = p; // RULE_24
                endcase
                sw = sat32(nv, 1'b0);
                // a direct multiply always lands in a data register
                doExt = c[dmma_pkg::CMD_EXT] || op == dmma_pkg::ACC_NONE;
                v     = (op == dmma_pkg::ACC_NONE) ? p : nv; // RULE_21

                if (c[dmma_pkg::CMD_EN]) begin
                    if (op != dmma_pkg::ACC_NONE) begin
                        // legacy mode keeps no extension bits
                        r_d.acc[u] = legacy ? {{8{sw[31]}}, sw[31:0]}
                                            : nv; // RULE_15
                        if (legacy) begin
                            v = r_d.acc[u];
                        end
                        r_d.accOvf[u]       = sw[32]; // RULE_01 RULE_02 RULE_06
                        r_d.accOvfSticky[u] = r_d.accOvfSticky[u]
                                              | sw[32]; // RULE_03 RULE_07
                    end
                    if (doExt) begin
                        ex     = extract(v, fmt, c[dmma_pkg::CMD_FULL], uns);
                        extAny = 1'b1;
                        extOvf = extOvf | ex[32];
                        if (c[dmma_pkg::CMD_FULL]) begin
                            r_d.res[u] = ex[31:0];
                        end else if (u == 0) begin
                            r_d.resHalf[15:0]  = ex[15:0]; // RULE_08
                        end else begin
                            r_d.resHalf[31:16] = ex[15:0]; // RULE_08
                        end
                    end
                end
            end
            if (extAny) begin
                r_d.extSat       = extOvf; // RULE_04 RULE_05 RULE_07
                r_d.extSatSticky = r_d.extSatSticky | extOvf; // RULE_04
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

endmodule

// ### src/dmma_pkg.sv
package dmma_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_OPND_A   = 8'h00;
    localparam logic [7:0] OFS_OPND_B   = 8'h04;
    localparam logic [7:0] OFS_CMD      = 8'h08;
    localparam logic [7:0] OFS_FLAGS    = 8'h0C;
    localparam logic [7:0] OFS_RES_ZERO = 8'h10;
    localparam logic [7:0] OFS_RES_ONE  = 8'h14;
    localparam logic [7:0] OFS_RES_HALF = 8'h18;
    localparam logic [7:0] OFS_ACC0_W   = 8'h20;
    localparam logic [7:0] OFS_ACC0_X   = 8'h24;
    localparam logic [7:0] OFS_ACC1_W   = 8'h28;
    localparam logic [7:0] OFS_ACC1_X   = 8'h2C;

    // ----------------------------------------------------------------
    // arith_flags_reg bit positions
    // ----------------------------------------------------------------
    localparam int FLG_ACC0_OVF  = 16;
    localparam int FLG_ACC0_STKY = 17;
    localparam int FLG_ACC1_OVF  = 18;
    localparam int FLG_ACC1_STKY = 19;
    localparam int FLG_EXT_SAT   = 24;
    localparam int FLG_EXT_STKY  = 25;

    // ----------------------------------------------------------------
    // command word: one byte per unit, then format and mixed bit
    // ----------------------------------------------------------------
    localparam int CMD_UNIT_W  = 8;
    localparam int CMD_OP_LO   = 0;
    localparam int CMD_EN      = 2;
    localparam int CMD_EXT     = 3;
    localparam int CMD_SEL_A   = 4;
    localparam int CMD_SEL_B   = 5;
    localparam int CMD_FULL    = 6;
    localparam int CMD_FMT_LO  = 16;
    localparam int CMD_MIX     = 20;

    localparam int ACC_W   = 40;
    localparam int EXT_W   = 8;
    localparam int WORD_W  = 32;
    localparam int HALF_W  = 16;

    localparam logic [39:0] RND_HALF   = 40'h00_0000_8000;
    localparam logic [15:0] MOST_NEG16 = 16'h8000;
    localparam logic [39:0] LEGACY_SQR = 40'h00_7FFF_FFFF;
    localparam logic [31:0] SMAX32     = 32'h7FFF_FFFF;
    localparam logic [31:0] SMIN32     = 32'h8000_0000;
    localparam logic [15:0] SMAX16     = 16'h7FFF;
    localparam logic [15:0] SMIN16     = 16'h8000;

    typedef enum logic [1:0] {
        ACC_NONE = 2'b00,
        ACC_LOAD = 2'b01,
        ACC_ADD  = 2'b10,
        ACC_SUB  = 2'b11
    } dmma_accop_e;

    typedef enum logic [3:0] {
        FMT_DEF         = 4'h0,
        FMT_SINT        = 4'h1,
        FMT_UFRAC       = 4'h2,
        FMT_UINT        = 4'h3,
        FMT_TRUNC       = 4'h4,
        FMT_UFRAC_TRUNC = 4'h5,
        FMT_SINT_X2     = 4'h6,
        FMT_INT_HIGH    = 4'h7,
        FMT_LEGACY      = 4'h8
    } dmma_fmt_e;

    typedef struct packed {
        logic [31:0]      opndA;
        logic [31:0]      opndB;
        logic [31:0]      cmd;
        logic             pend;
        logic             done;
        logic [1:0][39:0] acc;
        logic [1:0][31:0] res;
        logic [31:0]      resHalf;
        logic [1:0]       accOvf;
        logic [1:0]       accOvfSticky;
        logic             extSat;
        logic             extSatSticky;
        logic [31:0]      rdData;
    } dmma_state_s;

endpackage

// ### tb/dmma_monitor.sv
`timescale 1ns/100ps
module dmma_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    localparam logic [31:0] FMASK = 32'h030F_0000;
    logic        acc;
    logic        rdF;
    logic        fw;
    logic        cw;
    logic        unm;
    logic [2:0]  stk_q;
    logic        fok_q;
    logic [31:0] fwd_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    assign acc = psel & penable & pready;
    assign rdF = acc & ~pwrite & (paddr == dmma_pkg::OFS_FLAGS);
    assign fw  = acc & pwrite & (paddr == dmma_pkg::OFS_FLAGS);
    assign cw  = acc & pwrite & (paddr == dmma_pkg::OFS_CMD);
    assign unm = (paddr[1:0] != 2'h0) | (paddr > 8'h2C) | (paddr == 8'h1C);

    // sticky bits seen so far; only a flag write may drop them
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stk_q <= 3'h0;
            fok_q <= 1'b1;
            fwd_q <= 32'h0;
        end else if (fw) begin
            stk_q <= {pwdata[25], pwdata[19], pwdata[17]};
            fok_q <= 1'b1;
            fwd_q <= pwdata;
        end else begin
            if (rdF) stk_q <= stk_q | {prdata[25], prdata[19], prdata[17]};
            if (cw) fok_q <= 1'b0;
        end
    end

    property p_rsvd;
        rdF |-> (prdata & ~FMASK) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("stray flag bits");
    property p_ovfstk;
        rdF |-> (!prdata[16] || prdata[17]) && (!prdata[18] || prdata[19]);
    endproperty
    a_ovfstk: assert property (p_ovfstk)
        else $error("ovf without sticky");
    property p_satstk;
        rdF |-> !prdata[24] || prdata[25];
    endproperty
    a_satstk: assert property (p_satstk)
        else $error("sat without sticky");
    property p_keep;
        rdF |-> ({prdata[25], prdata[19], prdata[17]} & stk_q) == stk_q;
    endproperty
    a_keep: assert property (p_keep) else $error("sticky bit lost");
    property p_flgwr;
        rdF && fok_q |-> (prdata & FMASK) == (fwd_q & FMASK);
    endproperty
    a_flgwr: assert property (p_flgwr)
        else $error("flag write lost");
    property p_ext;
        acc && !pwrite && (paddr == dmma_pkg::OFS_ACC0_X
            || paddr == dmma_pkg::OFS_ACC1_X) |-> prdata[31:8] == 24'h0;
    endproperty
    a_ext: assert property (p_ext)
        else $error("extension too wide");
    property p_unmap;
        acc |-> pslverr == unm;
    endproperty
    a_unmap: assert property (p_unmap) else $error("bad error response");
    property p_wait;
        psel && penable && !pready |-> ##[1:2] pready;
    endproperty
    a_wait: assert property (p_wait) else $error("access stalls too long");
endmodule

// ### tb/dmma_apb_master.sv
`timescale 1ns/100ps
module dmma_apb_master (
    input  wire logic        ref_clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // called just after a rising edge; waits for pready without a limit
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge ref_clk);
    endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] OA  = dmma_pkg::OFS_OPND_A;
    localparam logic [7:0] OB  = dmma_pkg::OFS_OPND_B;
    localparam logic [7:0] CM  = dmma_pkg::OFS_CMD;
    localparam logic [7:0] FL  = dmma_pkg::OFS_FLAGS;
    localparam logic [7:0] RZ  = dmma_pkg::OFS_RES_ZERO;
    localparam logic [7:0] RO  = dmma_pkg::OFS_RES_ONE;
    localparam logic [7:0] RH  = dmma_pkg::OFS_RES_HALF;
    localparam logic [7:0] A0W = dmma_pkg::OFS_ACC0_W;
    localparam logic [7:0] A0X = dmma_pkg::OFS_ACC0_X;
    localparam logic [7:0] A1W = dmma_pkg::OFS_ACC1_W;
    logic        ref_clk = 1'b0;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] r;
    logic        e;
    int          err_count;
    int          cmp_count;

    dmma_core #(.ADDR_W(8)) uut (.ref_clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    dmma_apb_master mst (.ref_clk, .pready, .pslverr, .prdata, .psel,
        .penable, .pwrite, .paddr, .pwdata);

    always #20 ref_clk = ~ref_clk;

    task automatic test_done();
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        x;
        mst.xfer(1'b1, a, d, q, x);
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        x;
        mst.xfer(1'b0, a, 32'h0, q, x);
        cmp(q, exp);
    endtask

    task automatic run(input logic [31:0] a, b, c);
        wr(OA, a);
        wr(OB, b);
        wr(CM, c);
    endtask

    task automatic opck(input logic [31:0] a, b, c, input logic [7:0] ad,
                        input logic [31:0] exp);
        run(a, b, c);
        chk(ad, exp);
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        chk(FL, 32'h0);
        for (int k = 0; k < 4; k++) begin
            opck(32'h0005_0003, 32'h0007_0002,
                {12'h0, 4'h1, 10'h1, k[1:0], 4'h4}, RZ,
                (k[0] ? 32'h5 : 32'h3) * (k[1] ? 32'h7 : 32'h2));
        end
        opck(32'h4000, 32'h4000, 32'h44, RZ, 32'h2000_0000);
        opck(32'h3_FFFD, 32'h3_FFFD, 32'h1_0054, RZ, 32'hFFFF_FFF7);
        opck(32'h8000, 32'h8000, 32'h2_0044, RZ, 32'h4000_0000);
        opck(32'hFFFF, 32'h2, 32'h3_0044, RZ, 32'h1_FFFE);
        opck(32'h8000, 32'h8000, 32'h4D, RZ, 32'h7FFF_FFFF);
        chk(FL, 32'h0303_0000);
        opck(32'h8000, 32'h8000, 32'h8_004D, RZ, 32'h7FFF_FFFF);
        chk(A0X, 32'h0);
        chk(FL, 32'h0202_0000);
        wr(FL, 32'h0);
        chk(FL, 32'h0);
        run(32'h8000, 32'h8000, 32'h0500);
        chk(FL, 32'h000C_0000);
        opck(32'h4000, 32'h4000, 32'h44, RZ, 32'h2000_0000);
        chk(FL, 32'h000C_0000);
        run(32'h8000, 32'h8000, 32'h44);
        chk(FL, 32'h030C_0000);
        chk(A1W, 32'h8000_0000);
        run(32'h4000, 32'h4000, 32'h0500);
        chk(FL, 32'h0308_0000);
        run(32'h5_0003, 32'h7_0002, 32'h1_0005);
        run(32'h5_0003, 32'h7_0002, 32'h1_0036);
        chk(A0W, 32'h29);
        run(32'h5_0003, 32'h7_0002, 32'h1_0007);
        chk(A0W, 32'h23);
        run(32'h3_FFFD, 32'h3_FFFD, 32'h1_0015);
        chk(A0X, 32'hFF);
        opck(32'h5_0003, 32'h7_0002, 32'h1_3404, RH, 32'h23_0006);
        opck(32'h4001, 32'h4000, 32'h4_0404, RH, 32'h2000_2000);
        opck(32'h4001, 32'h4000, 32'h0404, RH, 32'h2001_2001);
        opck(32'h8001, 32'h8000, 32'h5_0404, RH, 32'h4000_4000);
        opck(32'h4000, 32'h2, 32'h6_0404, RH, 32'h7FFF_7FFF);
        opck(32'h4000, 32'h4000, 32'h6_0044, RZ, 32'h2000_0000);
        opck(32'h4000, 32'h6, 32'h7_0404, RH, 32'h2_0002);
        opck(32'hFFFF, 32'hFFFF, 32'h10_4444, RO, 32'hFFFF_0001);
        chk(RZ, 32'h2);
        opck(32'hFFFF, 32'hFFFF, 32'h11_4444, RO, 32'hFFFF_0001);
        chk(RZ, 32'h1);
        wr(RZ, 32'h0);
        chk(RZ, 32'h1);
        mst.xfer(1'b0, 8'h30, 32'h0, r, e);
        cmp({31'h0, e}, 32'h1);
        test_done();
    end
endmodule

bind dmma_core dmma_monitor #(.ADDR_W(ADDR_W)) mon (.ref_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
